// [inc/ptm_pkg.sv]
package ptm_pkg;
    // register offsets, byte addresses on the avalon bus
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_COUNT     = 4'h4;
    localparam logic [3:0] ADDR_PERIOD    = 4'h8;
    localparam logic [3:0] ADDR_IRQ       = 4'hc;
    // timer_control fields
    localparam int         PRE_LSB        = 0;
    localparam int         ON_BIT         = 2;
    localparam int         POST_LSB       = 3;
    localparam logic [7:0] CONTROL_MASK   = 8'h7f;
    // irq register fields
    localparam int         FLAG_BIT       = 0;
    localparam int         ENABLE_BIT     = 1;
    // reset values
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] PERIOD_RESET   = 8'hff;
    // instruction clock is the system clock divided by four
    localparam int         INSTR_DIV      = 4;
    localparam logic [1:0] INSTR_LAST     = 2'(INSTR_DIV - 1);
    // prescaler terminal counts
    localparam logic [5:0] PRE_LAST_1     = 6'h00;
    localparam logic [5:0] PRE_LAST_4     = 6'h03;
    localparam logic [5:0] PRE_LAST_16    = 6'h0f;
    localparam logic [5:0] PRE_LAST_64    = 6'h3f;
endpackage

// [inc/ptm_tick_if.sv]
`timescale 1ns/1ps
// carries the scaled tick from the divider to the timer core
interface ptm_tick_if;
    logic       tick;      // one-cycle prescaled tick
    logic       clear;     // clears the prescaler
    logic       run;       // timer_on
    logic       stall;     // processor sleeping
    logic [1:0] select;    // prescale_select
    modport divider (input clear, run, stall, select, output tick);
    modport core    (output clear, run, stall, select, input tick);
endinterface

// [src/ptm_prescaler.sv]
`timescale 1ns/1ps
// divides the system clock to the instruction clock, then by the prescale ratio
module ptm_prescaler
    import ptm_pkg::*;
(
    // clock and reset
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    // link to core
    ptm_tick_if.divider tk
);
    logic [1:0] instr_cnt;   // fosc/4 phase
    logic [5:0] pre_cnt;     // prescale count
    logic       instr_tick;  // one instruction cycle

    // prescale terminal decode
    function automatic logic [5:0] pre_last(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_last = PRE_LAST_1;
            2'h1:    pre_last = PRE_LAST_4;
            2'h2:    pre_last = PRE_LAST_16;
            default: pre_last = PRE_LAST_64;
        endcase
    endfunction

    // instruction clock enable, frozen while sleeping
    assign instr_tick = (instr_cnt == INSTR_LAST) && !tk.stall;

    // instruction phase counter
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            instr_cnt <= 2'h0;
        end else if (!tk.stall) begin
            instr_cnt <= instr_cnt + 2'h1;
        end
    end

    // prescale counter, cleared by count and control writes and reset, held when off
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt <= 6'h00;
        end else if (tk.clear) begin
            pre_cnt <= 6'h00;
        end else if (instr_tick && tk.run) begin
            if (pre_cnt >= pre_last(tk.select)) begin
                pre_cnt <= 6'h00;
            end else begin
                pre_cnt <= pre_cnt + 6'h01;
            end
        end
    end

    // tick at the end of each prescale period
    assign tk.tick = instr_tick && tk.run && !tk.clear && (pre_cnt >= pre_last(tk.select));
endmodule

// [src/ptm_timer.sv]
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module ptm_timer
    import ptm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic [1:0]       avs_response_out,
    // processor state
    input  wire logic        sleep_in,
    // peripheral outputs
    output logic             period_match_pulse_out,
    output logic             clc_match_out,
    output logic             nco_match_out,
    output logic             pwm_match_out,
    output logic             timer_irq_out
);
    ptm_tick_if tk ();                 // divider link

    logic [1:0]  rst_sync;             // reset release stages
    logic        rst_n;                // synchronised reset
    logic [7:0]  timer_control;        // control register
    logic [7:0]  timer_count;          // counter
    logic [7:0]  period_value;         // period
    logic [3:0]  post_cnt;             // postscale count
    logic        match_irq_flag;       // latched flag
    logic        match_irq_enable;     // interrupt enable
    logic        match_hold;           // match pulse register
    logic        clear_pending;        // clear count on next tick
    logic        acc_done;             // answer cycle
    logic        wr_en;                // write accepted
    logic        rd_en;                // read accepted
    logic        mapped;               // address decodes
    logic        wr_lane0;             // low byte enabled
    logic        wr_control;           // control write
    logic        wr_count;             // count write
    logic        wr_period;            // period write
    logic        wr_irq;               // irq register write
    logic        sleep_s1;             // sleep sync stage one
    logic        sleep_s2;             // sleep sync stage two
    logic        sleep_s3;             // sleep sync stage three
    logic        sleeping;             // filtered sleep
    logic        equal_now;            // count equals period
    logic        post_terminal;        // postscaler at terminal
    logic [31:0] next_readdata;        // read mux

    // reset release through two flip-flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // sleep level from the processor, three stages
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sleep_s1 <= 1'b0;
            sleep_s2 <= 1'b0;
            sleep_s3 <= 1'b0;
        end else begin
            sleep_s1 <= sleep_in;
            sleep_s2 <= sleep_s1;
            sleep_s3 <= sleep_s2;
        end
    end

    // sleep state changes once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sleeping <= 1'b0;
        end else if (sleep_s2 == sleep_s3) begin
            sleeping <= sleep_s3;
        end
    end

    // bus decode: one wait cycle, then the answer
    assign mapped              = (avs_address_in == ADDR_CONTROL) || (avs_address_in == ADDR_COUNT) ||
                                 (avs_address_in == ADDR_PERIOD) || (avs_address_in == ADDR_IRQ);
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !acc_done;
    assign wr_en               = avs_write_in && acc_done;
    assign rd_en               = avs_read_in && acc_done;
    assign wr_lane0            = wr_en && avs_byteenable_in[0];
    assign wr_control          = wr_lane0 && (avs_address_in == ADDR_CONTROL);
    assign wr_count            = wr_lane0 && (avs_address_in == ADDR_COUNT);
    assign wr_period           = wr_lane0 && (avs_address_in == ADDR_PERIOD);
    assign wr_irq              = wr_lane0 && (avs_address_in == ADDR_IRQ);

    // answer cycle toggles so each request waits once
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            acc_done <= 1'b0;
        end else if (acc_done) begin
            acc_done <= 1'b0;
        end else if (avs_read_in || avs_write_in) begin
            acc_done <= 1'b1;
        end
    end

    // read data mux
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address_in)
            ADDR_CONTROL: next_readdata = {24'h000000, timer_control & CONTROL_MASK};
            ADDR_COUNT:   next_readdata = {24'h000000, timer_count};
            ADDR_PERIOD:  next_readdata = {24'h000000, period_value};
            ADDR_IRQ:     next_readdata = {30'h00000000, match_irq_enable, match_irq_flag};
            default:      next_readdata = 32'h0000_0000;
        endcase
    end

    // read data and response registered for the answer cycle
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_out <= 32'h0000_0000;
            avs_response_out <= 2'h0;
        end else if ((avs_read_in || avs_write_in) && !acc_done) begin
            avs_readdata_out <= avs_read_in ? next_readdata : 32'h0000_0000;
            avs_response_out <= mapped ? 2'h0 : 2'h3;
        end
    end

    // control register, bit seven never stored
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            timer_control <= CONTROL_RESET;
        end else if (wr_control) begin
            timer_control <= avs_writedata_in[7:0] & CONTROL_MASK;
        end
    end

    // period register, all ones after reset
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            period_value <= PERIOD_RESET;
        end else if (wr_period) begin
            period_value <= avs_writedata_in[7:0];
        end
    end

    // divider link
    assign tk.clear  = wr_count || wr_control;
    assign tk.run    = timer_control[ON_BIT];
    assign tk.stall  = sleeping;
    assign tk.select = timer_control[PRE_LSB +: 2];

    ptm_prescaler u_pre (
        .clk_in   (clk_in),
        .rst_n_in (rst_n),
        .tk       (tk)
    );

    // compare every cycle
    assign equal_now = (timer_count == period_value);

    // counter: writes win, a match clears on the next tick, ticks count up
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            timer_count <= COUNT_RESET;
        end else if (wr_count) begin
            timer_count <= avs_writedata_in[7:0];
        end else if (tk.tick) begin
            if (clear_pending) begin
                timer_count <= COUNT_RESET;
            end else begin
                timer_count <= timer_count + 8'h01;
            end
        end
    end

    // match pulse registered from the tick that reaches the period
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            match_hold    <= 1'b0;
            clear_pending <= 1'b0;
        end else if (wr_count) begin
            clear_pending <= (avs_writedata_in[7:0] == period_value);
            match_hold    <= (avs_writedata_in[7:0] == period_value) && timer_control[ON_BIT];
        end else if (wr_period) begin
            clear_pending <= (timer_count == avs_writedata_in[7:0]);
            match_hold    <= (timer_count == avs_writedata_in[7:0]) && timer_control[ON_BIT];
        end else if (tk.tick) begin
            clear_pending <= clear_pending ? (period_value == COUNT_RESET) : (timer_count + 8'h01 == period_value);
            match_hold    <= clear_pending ? (period_value == COUNT_RESET) : (timer_count + 8'h01 == period_value);
        end else if (!timer_control[ON_BIT]) begin
            match_hold    <= 1'b0;
        end
    end

    // match stands for a whole prescaled period, while the count equals period
    assign period_match_pulse_out = match_hold && equal_now && timer_control[ON_BIT];
    assign clc_match_out          = period_match_pulse_out;
    assign nco_match_out          = period_match_pulse_out;
    assign pwm_match_out          = period_match_pulse_out;

    // postscaler terminal decode
    assign post_terminal = (post_cnt == timer_control[POST_LSB +: 4]);

    // postscaler clocked by the tick that ends a match period
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            post_cnt <= 4'h0;
        end else if (tk.clear) begin
            post_cnt <= 4'h0;
        end else if (tk.tick && clear_pending) begin
            post_cnt <= post_terminal ? 4'h0 : post_cnt + 4'h1;
        end
    end

    // irq flag: hardware set wins over software clear
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            match_irq_flag   <= 1'b0;
            match_irq_enable <= 1'b0;
        end else begin
            if (tk.tick && clear_pending && post_terminal && !tk.clear) begin
                match_irq_flag <= 1'b1;
            end else if (wr_irq) begin
                match_irq_flag <= avs_writedata_in[FLAG_BIT];
            end
            if (wr_irq) begin
                match_irq_enable <= avs_writedata_in[ENABLE_BIT];
            end
        end
    end

    // interrupt request gated by enable
    assign timer_irq_out = match_irq_flag && match_irq_enable;
endmodule

// [test/ptm_timer_checker.sv]
`timescale 1ns/1ps
// watches bus timing, readback and the match and irq outputs
module ptm_timer_checker
    import ptm_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [1:0]  avs_response_out,
    // timer side
    input wire logic        sleep_in,
    input wire logic        period_match_pulse_out,
    input wire logic        clc_match_out,
    input wire logic        nco_match_out,
    input wire logic        pwm_match_out,
    input wire logic        timer_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic mapped = (avs_address_in[1:0] == 2'h0); // only word offsets exist
    // read finishing this cycle
    sequence s_rd_done;
        avs_read_in && !avs_waitrequest_out;
    endsequence
    // asleep past the synchroniser and the filter, no writes
    sequence s_asleep;
        sleep_in [*6] ##0 !avs_write_in;
    endsequence
    property p_wait;
        $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_unmapped;
        s_rd_done ##0 !mapped |-> avs_readdata_out == 32'h0 && avs_response_out == 2'h3;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
    property p_ok;
        s_rd_done ##0 mapped |-> avs_response_out == 2'h0 && avs_readdata_out[31:8] == 24'h0;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped read wrong");
    property p_bit7;
        s_rd_done ##0 (avs_address_in == ADDR_CONTROL) |-> !avs_readdata_out[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("control bit 7 set");
    property p_peri;
        clc_match_out == period_match_pulse_out && nco_match_out == period_match_pulse_out
            && pwm_match_out == period_match_pulse_out;
    endproperty
    a_peri: assert property (p_peri) else $error("peripheral copy differs");
    property p_width;
        $rose(period_match_pulse_out) ##0 !avs_write_in [*3] |-> period_match_pulse_out [*2];
    endproperty
    a_width: assert property (p_width) else $error("match pulse short");
    property p_irq;
        $rose(timer_irq_out) |-> $past(avs_write_in) || $past(period_match_pulse_out);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    property p_sleep;
        s_asleep |-> $stable(period_match_pulse_out) && $stable(timer_irq_out);
    endproperty
    a_sleep: assert property (p_sleep) else $error("changed while asleep");
endmodule

bind ptm_timer ptm_timer_checker u_chk (
    .clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out, .sleep_in,
    .period_match_pulse_out, .clc_match_out, .nco_match_out, .pwm_match_out, .timer_irq_out
);

// [test/period_timer_with_scalers_test.sv]
`timescale 1ns/1ps
// drives the registers over the bus and measures match and irq
module period_timer_with_scalers_test
    import ptm_pkg::*;
;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} ptm_row_t;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    logic        sleep_in = 1'b0;
    logic [31:0] avs_readdata_out, q, q2;
    logic [1:0]  avs_response_out, r;
    logic        avs_waitrequest_out, period_match_pulse_out, clc_match_out, nco_match_out, pwm_match_out;
    logic        timer_irq_out;
    int          n_fail = 0;
    int          samples_checked = 0;
    logic [3:0]  posts [3] = '{4'h0, 4'h2, 4'hf}; // postscale choices
    // register cases: write flag, address, data, expected read, response
    ptm_row_t    rows [10] = '{
        '{1'b0, ADDR_CONTROL, 8'h00, 8'h00, 2'h0}, '{1'b0, ADDR_COUNT, 8'h00, 8'h00, 2'h0},
        '{1'b0, ADDR_PERIOD, 8'h00, 8'hff, 2'h0}, '{1'b0, ADDR_IRQ, 8'h00, 8'h00, 2'h0},
        '{1'b1, ADDR_PERIOD, 8'h55, 8'h55, 2'h0}, '{1'b1, ADDR_COUNT, 8'h33, 8'h33, 2'h0},
        '{1'b1, ADDR_CONTROL, 8'hf8, 8'h78, 2'h0}, '{1'b0, ADDR_COUNT, 8'h00, 8'h33, 2'h0},
        '{1'b1, ADDR_IRQ, 8'h02, 8'h02, 2'h0}, '{1'b1, 4'h1, 8'h11, 8'h00, 2'h3}};
    ptm_timer dut (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out, .sleep_in,
        .period_match_pulse_out, .clc_match_out, .nco_match_out, .pwm_match_out, .timer_irq_out);
    // 25 MHz clock
    always #20 clk_in = ~clk_in;
    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        avs_address_in   <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in     <= w;
        avs_read_in      <= !w;
        @(negedge clk_in);
        while (avs_waitrequest_out !== 1'b0 && k < 50) begin
            @(negedge clk_in);
            k++;
        end
        q = avs_readdata_out;
        r = avs_response_out;
        @(posedge clk_in);
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        @(posedge clk_in);
    endtask
    // compare one value
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // waits for a match pulse and counts its clocks
    task automatic width(output logic [31:0] n);
        int k;
        k = 0;
        n = 32'h0;
        @(negedge clk_in);
        while (period_match_pulse_out !== 1'b1 && k < 2000) begin
            @(negedge clk_in);
            k++;
        end
        while (period_match_pulse_out === 1'b1 && n < 2000) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in);
    endtask
    // reset low for n clocks, then settle
    task automatic do_reset(input int n);
        rst_n_in <= 1'b0;
        repeat (n) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask
    // walks the first n register cases
    task automatic run_rows(input int n);
        for (int i = 0; i < n; i++) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            chk({24'h0, rows[i].e}, q);
            chk({30'h0, rows[i].r}, {30'h0, r});
        end
    endtask
    // verdict
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset(10);
        run_rows(10);
        $display("registers done");
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, ADDR_CONTROL, 8'h00);
            bus(1'b1, ADDR_PERIOD, 8'h02);
            bus(1'b1, ADDR_COUNT, 8'h00);
            bus(1'b1, ADDR_CONTROL, 8'h04 | 8'(p));
            width(q2);
            chk(32'h4 << (2 * p), q2);
            bus(1'b0, ADDR_COUNT, 8'h00);
            if (p > 0) chk(32'h0, q);
        end
        $display("prescale done");
        foreach (posts[j]) begin
            bus(1'b1, ADDR_CONTROL, 8'h00);
            bus(1'b1, ADDR_COUNT, 8'h00);
            bus(1'b1, ADDR_PERIOD, 8'h01);
            bus(1'b1, ADDR_IRQ, 8'h02);
            bus(1'b1, ADDR_CONTROL, {1'b0, posts[j], 3'h4});
            for (int k = 0; k <= posts[j]; k++) begin
                width(q2);
                chk({31'h0, k == posts[j]}, {31'h0, timer_irq_out});
            end
        end
        bus(1'b1, ADDR_IRQ, 8'h01);
        chk(32'h0, {31'h0, timer_irq_out});
        bus(1'b1, ADDR_IRQ, 8'h03);
        chk(32'h1, {31'h0, timer_irq_out});
        $display("postscale done");
        bus(1'b1, ADDR_PERIOD, 8'hff);
        bus(1'b1, ADDR_COUNT, 8'h00);
        bus(1'b1, ADDR_CONTROL, 8'h04);
        repeat (40) @(posedge clk_in);
        sleep_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        bus(1'b0, ADDR_COUNT, 8'h00);
        q2 = q;
        repeat (40) @(posedge clk_in);
        bus(1'b0, ADDR_COUNT, 8'h00);
        chk(q2, q);
        sleep_in <= 1'b0;
        bus(1'b1, ADDR_CONTROL, 8'h00);
        bus(1'b0, ADDR_COUNT, 8'h00);
        q2 = q;
        repeat (40) @(posedge clk_in);
        avs_byteenable_in <= 4'h0;
        bus(1'b1, ADDR_COUNT, 8'h77);
        avs_byteenable_in <= 4'hf;
        bus(1'b0, ADDR_COUNT, 8'h00);
        chk(q2, q);
        $display("freeze done");
        do_reset(2);
        run_rows(4);
        $display("reset done");
        conclude();
    end
    // cuts a hang short
    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule
